//--- core/mtt_target.sv
// Operation
// - module holds presence line low while inserted
// - host reads/writes bytes, single or contiguous runs
// - explicit-address read and current-address read supported
// - host is master, module only ever slave
// - master starts every transfer, sets direction
// - link works at 400 kbit/s and 1 Mbit/s
// - data changes with SCL low; else START/STOP
// - ignore and never acknowledge while select high
// - long reset low restores all settings to defaults
`default_nettype none
module mtt_target #(
	parameter int MEM_DEPTH = 256,
	parameter int RESET_CYC = mtt_pkg::RESET_MIN_CYC
) (
	input  wire logic       clk_sys,  // system clock
	input  wire logic       rst,      // synchronous reset
	mtt_link_if.target      link,     // management link pins
	output logic            regWrite, // pulse: host wrote a byte
	output logic [7:0]      regAddr,  // address of written byte
	output logic [7:0]      regData,  // value of written byte
	output logic            busy      // a transfer is under way, from its START on
);
	localparam int PW = $clog2(MEM_DEPTH);

	typedef struct packed {
		logic                          scl1;
		logic                          scl2;
		logic                          sclPrev;
		logic                          sda1;
		logic                          sda2;
		logic                          sdaPrev;
		logic                          sel1;
		logic                          sel2;
		logic                          rst1;
		logic                          rst2;
		logic [15:0]                   rstCnt;
		mtt_pkg::mtt_tgt_state_t       state;
		logic [3:0]                    cnt;
		logic [7:0]                    sh;
		logic                          rw;
		logic                          ackPhase;
		logic                          acked;
		logic                          sdaOe;
		logic                          presentOe;
		logic [PW-1:0]                 ptr;
		logic                          regWrite;
		logic [7:0]                    regAddr;
		logic [7:0]                    regData;
		logic                          busy;
		logic [MEM_DEPTH-1:0][7:0]     mem;
	} mtt_tgt_reg_t;

	mtt_tgt_reg_t s;
	mtt_tgt_reg_t next_s;
	logic         sclRise;
	logic         sclFall;
	logic         startCond;
	logic         stopCond;
	logic         load;
	logic [7:0]   txByte;

	////////////////////////////////////////////////////////////////////////
	always_comb begin
		next_s    = s;
		load      = 1'b0;
		txByte    = s.mem[s.ptr];
		// first stages feed only second stages
		next_s.scl1    = link.scl;
		next_s.scl2    = s.scl1;
		next_s.sclPrev = s.scl2;
		next_s.sda1    = link.sda;
		next_s.sda2    = s.sda1;
		next_s.sdaPrev = s.sda2;
		next_s.sel1    = link.moduleSelectN;
		next_s.sel2    = s.sel1;
		next_s.rst1    = link.moduleResetN;
		next_s.rst2    = s.rst1;
		next_s.regWrite = 1'b0;
		next_s.presentOe = 1'b1;
		sclRise   = s.scl2 & ~s.sclPrev;
		sclFall   = ~s.scl2 & s.sclPrev;
		// SDA moving while SCL stays high marks a frame edge
		startCond = s.scl2 & s.sclPrev & s.sdaPrev & ~s.sda2;
		stopCond  = s.scl2 & s.sclPrev & ~s.sdaPrev & s.sda2;

		if (!s.rst2) begin
			next_s.state    = mtt_pkg::T_IDLE;
			next_s.sdaOe    = 1'b0;
			next_s.ackPhase = 1'b0;
			if (s.rstCnt < 16'(RESET_CYC))
				next_s.rstCnt = s.rstCnt + 16'h0001;
			// fires once, when the low level has lasted the full width
			if (s.rstCnt == 16'(RESET_CYC - 1)) begin
				next_s.mem = {MEM_DEPTH{mtt_pkg::MEM_RESET}};
				next_s.ptr = PW'(mtt_pkg::PTR_RESET);
			end
		end else if (s.sel2) begin
			// deselected: drop any transfer and keep SDA released
			next_s.rstCnt   = 16'h0000;
			next_s.state    = mtt_pkg::T_IDLE;
			next_s.sdaOe    = 1'b0;
			next_s.ackPhase = 1'b0;
		end else if (startCond) begin
			// a repeated start also lands here, pointer kept
			next_s.rstCnt   = 16'h0000;
			next_s.state    = mtt_pkg::T_DADDR;
			next_s.cnt      = 4'h0;
			next_s.sdaOe    = 1'b0;
			next_s.ackPhase = 1'b0;
		end else if (stopCond) begin
			next_s.rstCnt   = 16'h0000;
			next_s.state    = mtt_pkg::T_IDLE;
			next_s.sdaOe    = 1'b0;
			next_s.ackPhase = 1'b0;
		end else if (sclRise) begin
			next_s.rstCnt = 16'h0000;
			case (s.state)
				mtt_pkg::T_DADDR, mtt_pkg::T_RADDR, mtt_pkg::T_WDATA: begin
					if (!s.ackPhase && s.cnt < mtt_pkg::ACK_BIT) begin
						next_s.sh  = {s.sh[6:0], s.sda2};
						next_s.cnt = s.cnt + 4'h1;
					end
				end
				mtt_pkg::T_RACK: begin
					next_s.acked = ~s.sda2;
				end
				default: begin
				end
			endcase
		end else if (sclFall) begin
			next_s.rstCnt = 16'h0000;
			if (s.ackPhase) begin
				// end of our acknowledge bit
				next_s.ackPhase = 1'b0;
				next_s.sdaOe    = 1'b0;
				next_s.cnt      = 4'h0;
				case (s.state)
					mtt_pkg::T_DADDR: begin
						if (s.rw) begin
							next_s.state = mtt_pkg::T_RDATA;
							load         = 1'b1;
						end else begin
							next_s.state = mtt_pkg::T_RADDR;
						end
					end
					mtt_pkg::T_RADDR: begin
						next_s.state = mtt_pkg::T_WDATA;
					end
					default: begin
					end
				endcase
			end else begin
				case (s.state)
					mtt_pkg::T_DADDR: begin
						if (s.cnt == mtt_pkg::ACK_BIT) begin
							if (s.sh[7:1] == mtt_pkg::DEV_ADDR) begin
								next_s.rw       = s.sh[0];
								next_s.ackPhase = 1'b1;
								next_s.sdaOe    = 1'b1;
							end else begin
								next_s.state = mtt_pkg::T_IDLE;
							end
						end
					end
					mtt_pkg::T_RADDR: begin
						if (s.cnt == mtt_pkg::ACK_BIT) begin
							next_s.ptr      = PW'(s.sh);
							next_s.ackPhase = 1'b1;
							next_s.sdaOe    = 1'b1;
						end
					end
					mtt_pkg::T_WDATA: begin
						if (s.cnt == mtt_pkg::ACK_BIT) begin
							next_s.mem[s.ptr] = s.sh;
							next_s.regWrite   = 1'b1;
							next_s.regAddr    = 8'(s.ptr);
							next_s.regData    = s.sh;
							next_s.ptr        = s.ptr + PW'(1);
							next_s.ackPhase   = 1'b1;
							next_s.sdaOe      = 1'b1;
						end
					end
					mtt_pkg::T_RDATA: begin
						if (s.cnt == mtt_pkg::ACK_BIT) begin
							// byte out: release for the master's answer
							next_s.sdaOe = 1'b0;
							next_s.ptr   = s.ptr + PW'(1);
							next_s.state = mtt_pkg::T_RACK;
						end else begin
							next_s.sdaOe = ~s.sh[7];
							next_s.sh    = {s.sh[6:0], 1'b0};
							next_s.cnt   = s.cnt + 4'h1;
						end
					end
					mtt_pkg::T_RACK: begin
						// a not-acknowledge ends the run; wait for the stop
						if (s.acked) begin
							next_s.state = mtt_pkg::T_RDATA;
							load         = 1'b1;
						end else begin
							next_s.state = mtt_pkg::T_IDLE;
						end
					end
					default: begin
					end
				endcase
			end
			if (load) begin
				// drive bit 7 now, the rest on later falls
				next_s.sdaOe = ~txByte[7];
				next_s.sh    = {txByte[6:0], 1'b0};
				next_s.cnt   = 4'h1;
			end
		end else begin
			next_s.rstCnt = 16'h0000;
		end
		next_s.busy = (next_s.state != mtt_pkg::T_IDLE);
	end

	////////////////////////////////////////////////////////////////////////
	always_ff @(posedge clk_sys) begin
		if (rst) begin
			s           <= '0;
			s.scl1      <= 1'b1;
			s.scl2      <= 1'b1;
			s.sclPrev   <= 1'b1;
			s.sda1      <= 1'b1;
			s.sda2      <= 1'b1;
			s.sdaPrev   <= 1'b1;
			s.sel1      <= 1'b1;
			s.sel2      <= 1'b1;
			s.rst1      <= 1'b1;
			s.rst2      <= 1'b1;
			s.state     <= mtt_pkg::T_IDLE;
			s.presentOe <= 1'b1;
			s.ptr       <= PW'(mtt_pkg::PTR_RESET);
			s.mem       <= {MEM_DEPTH{mtt_pkg::MEM_RESET}};
		end else begin
			s <= next_s;
		end
	end

	////////////////////////////////////////////////////////////////////////
	// open-drain: only ever pull low, never drive SCL (no stretching)
	assign link.tgtSdaOut  = 1'b0;
	assign link.tgtSdaOe   = s.sdaOe;
	assign link.presentOut = 1'b0;
	assign link.presentOe  = s.presentOe;
	assign regWrite        = s.regWrite;
	assign regAddr         = s.regAddr;
	assign regData         = s.regData;
	assign busy            = s.busy;
endmodule // mtt_target
`default_nettype wire

//--- include/mtt_pkg.sv
`default_nettype none
package mtt_pkg;
	////////////////////////////////////////////////////////////////////////
	// timing
	localparam int CLK_NS        = 10;
	localparam int FM_BIT_NS     = 2500;
	localparam int FMP_BIT_NS    = 1000;
	// a bit period is a least time, so quarters round up
	localparam int FM_QTR_CYC    = (FM_BIT_NS + 4 * CLK_NS - 1) / (4 * CLK_NS);
	localparam int FMP_QTR_CYC   = (FMP_BIT_NS + 4 * CLK_NS - 1) / (4 * CLK_NS);
	localparam int RESET_MIN_NS  = 10000;
	localparam int RESET_MIN_CYC = (RESET_MIN_NS + CLK_NS - 1) / CLK_NS;
	////////////////////////////////////////////////////////////////////////
	// link constants
	localparam logic [6:0] DEV_ADDR  = 7'h50;
	localparam logic [7:0] MEM_RESET = 8'h00;
	localparam logic [7:0] PTR_RESET = 8'h00;
	localparam logic [3:0] ACK_BIT   = 4'h8;
	////////////////////////////////////////////////////////////////////////
	// states
	typedef enum logic [2:0] {
		T_IDLE  = 3'h0,
		T_DADDR = 3'h1,
		T_RADDR = 3'h2,
		T_WDATA = 3'h3,
		T_RDATA = 3'h4,
		T_RACK  = 3'h5
	} mtt_tgt_state_t;
	typedef enum logic [1:0] {
		H_IDLE  = 2'h0,
		H_START = 2'h1,
		H_BYTE  = 2'h2,
		H_STOP  = 2'h3
	} mtt_host_state_t;
	typedef enum logic [1:0] {
		S_DA = 2'h0,
		S_RA = 2'h1,
		S_WD = 2'h2,
		S_RD = 2'h3
	} mtt_stage_t;
endpackage
`default_nettype wire

//--- include/mtt_link_if.sv
`default_nettype none
interface mtt_link_if;
	logic hostSclOut;
	logic hostSclOe;
	logic hostSdaOut;
	logic hostSdaOe;
	logic tgtSdaOut;
	logic tgtSdaOe;
	logic presentOut;
	logic presentOe;
	logic moduleSelectN;
	logic moduleResetN;
	logic scl;
	logic sda;
	logic modulePresentN;
	// open-drain wires with host-side pull-ups
	assign scl            = ~(hostSclOe & ~hostSclOut);
	assign sda            = ~((hostSdaOe & ~hostSdaOut) | (tgtSdaOe & ~tgtSdaOut));
	assign modulePresentN = ~(presentOe & ~presentOut);
	modport host (
		output hostSclOut, hostSclOe, hostSdaOut, hostSdaOe, moduleSelectN, moduleResetN,
		input  scl, sda, modulePresentN
	);
	modport target (
		output tgtSdaOut, tgtSdaOe, presentOut, presentOe,
		input  scl, sda, moduleSelectN, moduleResetN
	);
endinterface
`default_nettype wire

//--- core/mtt_host.sv
`default_nettype none
module mtt_host (
	input  wire logic       clk_sys,      // system clock
	input  wire logic       rst,          // synchronous reset
	mtt_link_if.host        link,         // management link pins
	input  wire logic       rateFastPlus, // 1: 1 Mbit/s, 0: 400 kbit/s
	input  wire logic       selectModule, // 1: pull select low
	input  wire logic       resetModule,  // 1: pull module reset low
	input  wire logic       cmdValid,     // command offered
	output logic            cmdReady,     // engine idle
	input  wire logic       cmdWrite,     // 1 write, 0 read
	input  wire logic       cmdExplicit,  // read with address phase
	input  wire logic [7:0] cmdAddr,      // register address
	input  wire logic [7:0] cmdLen,       // byte count, 0 acts as 1
	input  wire logic [7:0] wrData,       // next write byte
	output logic            wrTake,       // pulse: wrData consumed
	output logic            rdValid,      // pulse: rdData valid
	output logic [7:0]      rdData,       // read byte
	output logic            done,         // pulse: command finished
	output logic            nack,         // with done: target refused
	output logic            present       // module detected
);
	typedef struct packed {
		logic                    sda1;
		logic                    sda2;
		logic                    pres1;
		logic                    pres2;
		mtt_pkg::mtt_host_state_t state;
		mtt_pkg::mtt_stage_t     stage;
		logic [1:0]              qc;
		logic [7:0]              div;
		logic [3:0]              bitIdx;
		logic [7:0]              sh;
		logic                    write;
		logic                    explicitRd;
		logic [7:0]              addr;
		logic [7:0]              left;
		logic                    ackOk;
		logic                    refused;
		logic                    sclHigh;
		logic                    sdaOe;
		logic                    selN;
		logic                    rstN;
		logic                    cmdReady;
		logic                    wrTake;
		logic                    rdValid;
		logic [7:0]              rdData;
		logic                    done;
		logic                    nack;
	} mtt_host_reg_t;

	mtt_host_reg_t s;
	mtt_host_reg_t next_s;
	logic          tick;
	logic          tx;
	logic [7:0]    qtr;

	////////////////////////////////////////////////////////////////////////
	always_comb begin
		next_s = s;
		next_s.sda1    = link.sda;
		next_s.sda2    = s.sda1;
		// kept inverted so the present output is a plain flop
		next_s.pres1   = ~link.modulePresentN;
		next_s.pres2   = s.pres1;
		next_s.selN    = ~selectModule;
		next_s.rstN    = ~resetModule;
		next_s.wrTake  = 1'b0;
		next_s.rdValid = 1'b0;
		next_s.done    = 1'b0;
		next_s.nack    = 1'b0;
		qtr  = rateFastPlus ? 8'(mtt_pkg::FMP_QTR_CYC) : 8'(mtt_pkg::FM_QTR_CYC);
		tick = (s.div == 8'h00);
		tx   = (s.stage != mtt_pkg::S_RD);
		// quarter-bit enable; SCL edges fall on quarter boundaries
		if (s.state != mtt_pkg::H_IDLE)
			next_s.div = tick ? qtr - 8'h01 : s.div - 8'h01;

		case (s.state)
			mtt_pkg::H_IDLE: begin
				next_s.cmdReady = 1'b1;
				if (cmdValid && s.cmdReady) begin
					next_s.cmdReady   = 1'b0;
					next_s.write      = cmdWrite;
					next_s.explicitRd = cmdExplicit;
					next_s.addr       = cmdAddr;
					next_s.left       = (cmdLen == 8'h00) ? 8'h01 : cmdLen;
					next_s.stage      = mtt_pkg::S_DA;
					next_s.sh         = {mtt_pkg::DEV_ADDR, ~cmdWrite & ~cmdExplicit};
					next_s.refused    = 1'b0;
					next_s.state      = mtt_pkg::H_START;
					next_s.qc         = 2'h0;
					next_s.div        = 8'h00;
					next_s.bitIdx     = 4'h0;
				end
			end
			mtt_pkg::H_START: begin
				if (tick) begin
					next_s.qc = s.qc + 2'h1;
					case (s.qc)
						2'h0: next_s.sdaOe   = 1'b0;
						2'h1: next_s.sclHigh = 1'b1;
						2'h2: next_s.sdaOe   = 1'b1; // START: SDA falls, SCL high
						default: begin
							next_s.sclHigh = 1'b0;
							next_s.state   = mtt_pkg::H_BYTE;
						end
					endcase
				end
			end
			mtt_pkg::H_BYTE: begin
				if (tick) begin
					next_s.qc = s.qc + 2'h1;
					case (s.qc)
						2'h0: begin
							// SDA only moves in the low quarter
							if (s.bitIdx < mtt_pkg::ACK_BIT)
								next_s.sdaOe = tx & ~s.sh[7];
							else
								next_s.sdaOe = ~tx & (s.left != 8'h01);
						end
						2'h1: next_s.sclHigh = 1'b1;
						2'h2: begin
							if (s.bitIdx < mtt_pkg::ACK_BIT && !tx)
								next_s.sh = {s.sh[6:0], s.sda2};
							if (s.bitIdx == mtt_pkg::ACK_BIT && tx)
								next_s.ackOk = ~s.sda2;
						end
						default: begin
							next_s.sclHigh = 1'b0;
							if (s.bitIdx < mtt_pkg::ACK_BIT) begin
								if (tx)
									next_s.sh = {s.sh[6:0], s.sh[7]};
								next_s.bitIdx = s.bitIdx + 4'h1;
							end else begin
								next_s.bitIdx = 4'h0;
								case (s.stage)
									mtt_pkg::S_DA: begin
										if (!s.ackOk) begin
											next_s.refused = 1'b1;
											next_s.state   = mtt_pkg::H_STOP;
										end else if (s.sh[0]) begin
											// rotation hands the byte back, direction in bit 0
											next_s.stage = mtt_pkg::S_RD;
										end else begin
											next_s.stage = mtt_pkg::S_RA;
											next_s.sh    = s.addr;
										end
									end
									mtt_pkg::S_RA: begin
										if (!s.ackOk) begin
											next_s.refused = 1'b1;
											next_s.state   = mtt_pkg::H_STOP;
										end else if (s.write) begin
											next_s.stage  = mtt_pkg::S_WD;
											next_s.sh     = wrData;
											next_s.wrTake = 1'b1;
										end else begin
											next_s.stage = mtt_pkg::S_DA;
											next_s.sh    = {mtt_pkg::DEV_ADDR, 1'b1};
											next_s.state = mtt_pkg::H_START;
										end
									end
									mtt_pkg::S_WD: begin
										if (!s.ackOk || s.left == 8'h01) begin
											next_s.refused = ~s.ackOk;
											next_s.state   = mtt_pkg::H_STOP;
										end else begin
											next_s.left   = s.left - 8'h01;
											next_s.sh     = wrData;
											next_s.wrTake = 1'b1;
										end
									end
									default: begin
										next_s.rdValid = 1'b1;
										next_s.rdData  = s.sh;
										if (s.left == 8'h01)
											next_s.state = mtt_pkg::H_STOP;
										else
											next_s.left = s.left - 8'h01;
									end
								endcase
							end
						end
					endcase
				end
			end
			default: begin
				if (tick) begin
					next_s.qc = s.qc + 2'h1;
					case (s.qc)
						2'h0: next_s.sdaOe   = 1'b1;
						2'h1: next_s.sclHigh = 1'b1;
						2'h2: next_s.sdaOe   = 1'b0; // STOP: SDA rises, SCL high
						default: begin
							next_s.state    = mtt_pkg::H_IDLE;
							next_s.done     = 1'b1;
							next_s.nack     = s.refused;
							next_s.cmdReady = 1'b1;
						end
					endcase
				end
			end
		endcase
	end

	////////////////////////////////////////////////////////////////////////
	always_ff @(posedge clk_sys) begin
		if (rst) begin
			s         <= '0;
			s.sda1    <= 1'b1;
			s.sda2    <= 1'b1;
			s.state   <= mtt_pkg::H_IDLE;
			s.sclHigh <= 1'b1;
			s.selN    <= 1'b1;
			s.rstN    <= 1'b1;
		end else begin
			s <= next_s;
		end
	end

	assign link.hostSclOut    = 1'b0;
	assign link.hostSclOe     = ~s.sclHigh;
	assign link.hostSdaOut    = 1'b0;
	assign link.hostSdaOe     = s.sdaOe;
	assign link.moduleSelectN = s.selN;
	assign link.moduleResetN  = s.rstN;
	assign cmdReady           = s.cmdReady;
	assign wrTake             = s.wrTake;
	assign rdValid            = s.rdValid;
	assign rdData             = s.rdData;
	assign done               = s.done;
	assign nack               = s.nack;
	assign present            = s.pres2;
endmodule // mtt_host
`default_nettype wire

//--- sim/mtt_link_monitor.sv
`default_nettype none
module mtt_link_monitor (
	input wire logic clk_sys,        // system clock
	input wire logic rst,            // synchronous reset
	input wire logic hostSdaOe,      // host pulls sda
	input wire logic tgtSdaOe,       // target pulls sda
	input wire logic moduleSelectN,  // select pin level
	input wire logic moduleResetN,   // module reset pin level
	input wire logic scl,            // resolved clock wire
	input wire logic sda,            // resolved data wire
	input wire logic modulePresentN  // resolved presence wire
);
	timeunit 1ns;
	timeprecision 100ps;
	default clocking cb @(posedge clk_sys);
	endclocking
	default disable iff (rst);
	////////////////////////////////////////////////////////////////////////
	AST_PRESENT_LOW:
	assert property (!modulePresentN) else $error("presence line not low");
	AST_TGT_EDGE_SCL_LOW:
	assert property ($changed(tgtSdaOe) |-> !scl) else $error("target moved sda with scl high");
	AST_SEL_QUIET:
	assert property (moduleSelectN |-> !tgtSdaOe) else $error("target drove sda while deselected");
	// two sync flops plus the registered sdaOe before the target must let go
	AST_RESET_QUIET:
	assert property (!moduleResetN && !$past(moduleResetN, 3) |-> !tgtSdaOe)
		else $error("target drove sda during module reset");
	AST_SCL_HIGH_MIN:
	assert property ($rose(scl) |-> scl[*8]) else $error("scl high phase too short");
	AST_SCL_LOW_MIN:
	assert property ($fell(scl) |=> !scl[*8]) else $error("scl low phase too short");
	AST_START_BY_HOST:
	assert property ($fell(sda) && scl && $past(scl) |-> hostSdaOe && !tgtSdaOe)
		else $error("start not made by host");
	AST_STOP_RELEASED:
	assert property ($rose(sda) && scl && $past(scl) |-> !tgtSdaOe)
		else $error("target held sda at stop");
	////////////////////////////////////////////////////////////////////////
	cover property ($rose(tgtSdaOe));
	cover property ($fell(sda) && scl);
	cover property ($fell(moduleResetN));
endmodule // mtt_link_monitor
`default_nettype wire

//--- sim/mtt_target_bench.sv
`default_nettype none
module mtt_target_bench;
	timeunit 1ns;
	timeprecision 100ps;
	localparam int RST_CYC = 8;
	logic       clk_sys      = 1'b0;
	logic       rst          = 1'b1;
	logic       rateFastPlus = 1'b1;
	logic       selectModule = 1'b1;
	logic       resetModule  = 1'b0;
	logic       cmdValid     = 1'b0;
	logic       cmdWrite     = 1'b0;
	logic       cmdExplicit  = 1'b0;
	logic [7:0] cmdAddr      = 8'h00;
	logic [7:0] cmdLen       = 8'h00;
	logic [7:0] wrData       = 8'h00;
	logic       cmdReady, wrTake, rdValid, done, nack, present, regWrite, busy;
	logic [7:0] rdData, regAddr, regData, ptr, lfsrState, a, n;
	logic [7:0] mem [256];
	logic [7:0] wq[$], ea[$], ed[$];
	int         fail_count = 0;
	int         n_checks   = 0;
	mtt_link_if link ();
	mtt_host mtt_host_inst (.clk_sys(clk_sys), .rst(rst), .link(link),
		.rateFastPlus(rateFastPlus), .selectModule(selectModule), .resetModule(resetModule),
		.cmdValid(cmdValid), .cmdReady(cmdReady), .cmdWrite(cmdWrite),
		.cmdExplicit(cmdExplicit), .cmdAddr(cmdAddr), .cmdLen(cmdLen), .wrData(wrData),
		.wrTake(wrTake), .rdValid(rdValid), .rdData(rdData), .done(done), .nack(nack),
		.present(present));
	mtt_target #(.RESET_CYC(RST_CYC)) mtt_target_inst (.clk_sys(clk_sys), .rst(rst),
		.link(link), .regWrite(regWrite), .regAddr(regAddr), .regData(regData), .busy(busy));
	mtt_link_monitor mtt_link_monitor_inst (.clk_sys(clk_sys), .rst(rst),
		.hostSdaOe(link.hostSdaOe), .tgtSdaOe(link.tgtSdaOe),
		.moduleSelectN(link.moduleSelectN), .moduleResetN(link.moduleResetN),
		.scl(link.scl), .sda(link.sda), .modulePresentN(link.modulePresentN));
	always #5 clk_sys = ~clk_sys;
	////////////////////////////////////////////////////////////////////////
	function automatic logic [7:0] rnd();
		lfsrState = {lfsrState[6:0], lfsrState[7] ^ lfsrState[5] ^ lfsrState[4] ^ lfsrState[3]};
		return lfsrState;
	endfunction
	task automatic tick();
		@(posedge clk_sys);
		#1;
	endtask
	task automatic chk8(input logic [7:0] got, input logic [7:0] exp, input string what);
		n_checks++;
		if (got !== exp) begin
			fail_count++;
			$display("[ERR] %0t %s got %h exp %h", $time, what, got, exp);
		end
	endtask
	task automatic chk1(input logic got, input logic exp, input string what);
		chk8({7'h00, got}, {7'h00, exp}, what);
	endtask
	task automatic give_verdict();
		$display("checks %0d mismatches %0d", n_checks, fail_count);
		if (fail_count == 0 && n_checks > 0)
			$display("SIMULATION PASSED");
		else
			$display("SIMULATION FAILED");
		$finish;
	endtask
	////////////////////////////////////////////////////////////////////////
	// one command, start to done; the model updates only when the target is expected to ack
	task automatic run_cmd(input logic w, input logic ex, input logic [7:0] ad,
		input logic [7:0] len, input logic acc);
		int k;
		int bytes;
		int reads;
		logic sawBusy;
		bytes = (len == 8'h00) ? 1 : int'(len);
		reads = 0;
		wq.delete();
		for (k = 0; k < bytes; k++)
			wq.push_back(rnd());
		if (acc && (w || ex))
			ptr = ad;
		for (k = 0; acc && w && k < bytes; k++) begin
			ea.push_back(ptr + 8'(k));
			ed.push_back(wq[k]);
		end
		// the target's pointer ends just past the last written byte
		if (acc && w)
			ptr = ptr + 8'(bytes);
		sawBusy = 1'b0;
		k = 0;
		while (cmdReady !== 1'b1 && k < 2000) begin
			tick();
			k++;
		end
		chk1(cmdReady, 1'b1, "ready for command");
		cmdWrite = w;
		cmdExplicit = ex;
		cmdAddr = ad;
		cmdLen = len;
		wrData = wq[0];
		cmdValid = 1'b1;
		tick();
		cmdValid = 1'b0;
		k = 0;
		while (done !== 1'b1 && k < 60000) begin
			tick();
			k++;
			if (busy === 1'b1)
				sawBusy = 1'b1;
			if (wrTake === 1'b1) begin
				void'(wq.pop_front());
				wrData = (wq.size() > 0) ? wq[0] : 8'h00;
			end
			if (regWrite === 1'b1 && ea.size() > 0) begin
				chk8(regAddr, ea.pop_front(), "write address");
				chk8(regData, ed[0], "write data");
				mem[regAddr] = ed.pop_front();
			end else if (regWrite === 1'b1) begin
				chk1(1'b1, 1'b0, "unexpected write");
			end
			if (rdValid === 1'b1) begin
				chk8(rdData, mem[ptr], "read data");
				ptr = ptr + 8'h01;
				reads++;
			end
		end
		chk1(done, 1'b1, "command done");
		chk1(nack, !acc, "nack");
		chk1(sawBusy, acc, "target engaged");
		chk1(busy, 1'b0, "target idle after stop");
		chk8(8'(reads), (acc && !w) ? 8'(bytes) : 8'h00, "read count");
		chk8(8'(ea.size()), 8'h00, "writes left");
		if (k >= 60000)
			give_verdict();
	endtask
	task automatic module_reset(input int cyc);
		int i;
		resetModule = 1'b1;
		repeat (cyc) tick();
		resetModule = 1'b0;
		repeat (4) tick();
		if (cyc > RST_CYC + 3) begin
			for (i = 0; i < 256; i++)
				mem[i] = 8'h00;
			ptr = 8'h00;
		end
	endtask
	////////////////////////////////////////////////////////////////////////
	initial begin
		int i;
		for (i = 0; i < 256; i++)
			mem[i] = 8'h00;
		ptr = 8'h00;
		lfsrState = 8'h40;
		repeat (4) tick();
		rst = 1'b0;
		run_cmd(1'b0, 1'b0, 8'h00, 8'h02, 1'b1);
		chk1(present, 1'b1, "present");
		run_cmd(1'b1, 1'b1, 8'hfe, 8'h04, 1'b1);
		run_cmd(1'b0, 1'b1, 8'hfe, 8'h03, 1'b1);
		run_cmd(1'b0, 1'b0, 8'h00, 8'h02, 1'b1);
		run_cmd(1'b1, 1'b1, 8'h40, 8'h00, 1'b1);
		for (i = 0; i < 4; i++) begin
			a = rnd();
			// short runs keep each command inside its 60000-cycle wait for done
			n = rnd();
			n = {7'h00, n[0]} + 8'h01;
			run_cmd(1'b1, 1'b1, a, n, 1'b1);
			run_cmd(1'b0, 1'b1, a, n, 1'b1);
		end
		// slow rate costs 2.5x the cycles, so one short pair only
		rateFastPlus = 1'b0;
		a = rnd();
		run_cmd(1'b1, 1'b1, a, 8'h02, 1'b1);
		run_cmd(1'b0, 1'b1, a, 8'h02, 1'b1);
		rateFastPlus = 1'b1;
		selectModule = 1'b0;
		run_cmd(1'b1, 1'b1, a, 8'h01, 1'b0);
		run_cmd(1'b0, 1'b0, a, 8'h01, 1'b0);
		selectModule = 1'b1;
		run_cmd(1'b0, 1'b1, a, 8'h02, 1'b1);
		module_reset(3);
		run_cmd(1'b0, 1'b1, a, 8'h01, 1'b1);
		module_reset(RST_CYC + 6);
		run_cmd(1'b0, 1'b0, 8'h00, 8'h02, 1'b1);
		run_cmd(1'b0, 1'b1, a, 8'h02, 1'b1);
		give_verdict();
	end
endmodule // mtt_target_bench
`default_nettype wire
